// ---- buck_ctrl_pkg.sv ----
// constants, register map and reset values of the multi-output buck control block
package buck_ctrl_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int NUM_RAILS = 4;
    localparam int CODE_W = 5;
    localparam int LV_CODE_W = 4;
    localparam int IDLE_CNT_W = 10;
    localparam int SW_CNT_W = 7;
    localparam int EV_W = 4;

    // rail order: 0 low_rail, 1 mid_rail, 2 core rail, 3 periph_rail
    localparam logic [ADDR_W-1:0] OFS_CTRL0 = 32'h5000_0082;
    localparam logic [ADDR_W-1:0] OFS_CTRL1 = 32'h5000_0084;
    localparam logic [ADDR_W-1:0] OFS_TIMEOUT_TRIM = 32'h5000_0086;
    localparam logic [ADDR_W-1:0] OFS_RAIL0 [NUM_RAILS] =
        '{32'h5000_0088, 32'h5000_008C, 32'h0500_0090, 32'h5000_0094};
    localparam logic [ADDR_W-1:0] OFS_RAIL1 [NUM_RAILS] =
        '{32'h5000_008A, 32'h0500_008E, 32'h5000_0092, 32'h5000_0096};
    localparam logic [ADDR_W-1:0] OFS_STATUS = 32'h5000_00C0;
    localparam logic [ADDR_W-1:0] OFS_ILIM_LO = 32'h5000_00C2;
    localparam logic [ADDR_W-1:0] OFS_ILIM_HI = 32'h5000_00C4;

    // reset values and writable masks
    localparam logic [DATA_W-1:0] CTRL0_RST = 16'h2F24;
    localparam logic [DATA_W-1:0] CTRL0_MASK = 16'h7FFF;
    localparam logic [DATA_W-1:0] CTRL1_RST = 16'h5410;
    localparam logic [DATA_W-1:0] TIMEOUT_TRIM_RST = 16'h882D;
    localparam logic [DATA_W-1:0] RAIL0_RST [NUM_RAILS] =
        '{16'hA1A4, 16'hE3E4, 16'hC304, 16'hE3E4};
    localparam logic [DATA_W-1:0] RAIL1_RST [NUM_RAILS] =
        '{16'hD890, 16'hBC90, 16'hEC90, 16'hBC90};
    localparam logic [CODE_W-1:0] ILIM_RST = 5'h04;

    // field positions
    localparam int CTRL0_BROWNOUT = 13;
    localparam int CTRL0_MODE_LSB = 0;
    localparam int CTRL1_GLOBAL_IDLE_LSB = 5;
    localparam int CTRL1_GLOBAL_IDLE_W = 6;
    localparam int CTRL1_SW_LIMIT_LSB = 0;
    localparam int TT_IRQ_THR_LSB = 12;
    localparam int TT_CLR_RUN_LSB = 8;
    localparam int TT_SENSE_LSB = 6;
    localparam int TT_LSSUP_LSB = 3;
    localparam int TT_HSGND_LSB = 0;
    localparam int R0_FAST = 15;
    localparam int R0_VOLT_LSB = 10;
    localparam int R0_MAX_HV_LSB = 5;
    localparam int R0_MIN_LSB = 0;
    localparam int R1_EN_HV = 15;
    localparam int R1_EN_LV = 14;
    localparam int R1_MAX_LV_LSB = 10;
    localparam int R1_HYST_LSB = 5;
    localparam int R1_IDLE_MIN_LSB = 0;

    // input synchroniser lanes
    localparam int SYNC_BATT = 0;
    localparam int SYNC_SW = 1;
    localparam int SYNC_CHG = 2;
    localparam int SYNC_IDLE0 = 3;
    localparam int SYNC_W = SYNC_IDLE0 + NUM_RAILS;

    // converter modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0, MODE_ACTIVE = 2'h1, MODE_SLEEP = 2'h2, MODE_OFF2 = 2'h3
    } conv_mode_t;

    // analog meaning of the codes (decoded by the analog side)
    localparam int LSSUP_BASE_MV = 2000;
    localparam int LSSUP_STEP_MV = 100;
    localparam int HSGND_BASE_MV = 2200;
    localparam int HSGND_STEP_MV = 200;
    localparam int RAIL_BASE_MV = 1200;
    localparam int CORE_BASE_MV = 800;
    localparam int VOLT_STEP_MV = 25;
    localparam int ILIM_UNIT_MA = 30;
    localparam int SENSE_STEP_PCT = 4;
    localparam int BROWNOUT_MV = 2500;

    // timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int IDLE_STEP_PS = 125000;
    localparam int SW_STEP_PS = 62500;
    localparam int IDLE_STEP_CYC = IDLE_STEP_PS / CLK_PERIOD_PS;
    localparam int SW_STEP_CYC = (SW_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // adaptation step sizes
    localparam logic [6:0] STEP_NORMAL = 7'h01;
    localparam logic [6:0] STEP_FAST = 7'h02;
    localparam logic [6:0] STEP_FAST_DOWN = 7'h04;
endpackage

// ---- buck_multi_output_regulation_ctrl.sv ----
// register file, timeout counting and per-rail current limit adaptation of the buck converter
// Notes on behaviour
// - count timeouts, interrupt at threshold, reset eight
// - clean charge run clears timeout counter
// - sense trim adds 0/4/8/12 percent
// - low-side supply is 2 V plus 100 mV/step
// - high-side ground is battery minus 2.2 V+200 mV/step
// - per-rail fast ramp bit, set at reset
// - non-core voltage 1.2 V plus 25 mV/step
// - core voltage 0.8 V plus 25 mV/step
// - per-rail minimum limit code, reset four
// - per-rail high-battery maximum limit code
// - low-battery maximum replaces high-battery maximum
// - per-rail enable in high battery mode
// - per-rail enable in low battery mode
// - short idle raises current limit
// - maximum idle is minimum plus hysteresis
// - long idle lowers current limit
// - brownout option selects low battery settings
// - switch closed too long makes timeout event
// - idle past global ceiling ramps down faster
`timescale 1ns/1ps
module buck_multi_output_regulation_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [buck_ctrl_pkg::ADDR_W-1:0] addr,
    input wire logic [buck_ctrl_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [buck_ctrl_pkg::DATA_W-1:0] rd_data,
    input wire logic batt_below_2v5,
    input wire logic switch_closed,
    input wire logic charge_done,
    input wire logic [buck_ctrl_pkg::NUM_RAILS-1:0] rail_idle,
    output logic converter_active,
    output logic converter_sleep,
    output logic low_batt_mode,
    output logic switch_force_next,
    output logic timeout_irq,
    output logic [1:0] sense_current_trim,
    output logic [2:0] low_side_supply_trim,
    output logic [2:0] high_side_ground_trim,
    output logic [buck_ctrl_pkg::NUM_RAILS*buck_ctrl_pkg::CODE_W-1:0] rail_voltage_code,
    output logic [buck_ctrl_pkg::NUM_RAILS-1:0] rail_fast_ramp,
    output logic [buck_ctrl_pkg::NUM_RAILS-1:0] rail_charge_en,
    output logic [buck_ctrl_pkg::NUM_RAILS*buck_ctrl_pkg::CODE_W-1:0] adaptive_current_limit
);
    localparam int NR = buck_ctrl_pkg::NUM_RAILS;
    localparam int CW = buck_ctrl_pkg::CODE_W;
    localparam int IW = buck_ctrl_pkg::IDLE_CNT_W;
    localparam int SWW = buck_ctrl_pkg::SW_CNT_W;
    localparam int EW = buck_ctrl_pkg::EV_W;
    localparam int SYW = buck_ctrl_pkg::SYNC_W;

    logic [15:0] ctrl0_q;
    logic [15:0] ctrl1_q;
    logic [15:0] tt_q;
    logic [15:0] rail0_q [NR];
    logic [15:0] rail1_q [NR];
    logic [CW-1:0] ilim_q [NR];
    logic [15:0] rd_mux;
    logic [15:0] rd_data_q;
    logic [SYW-1:0] sync1_q;
    logic [SYW-1:0] sync2_q;
    logic [SYW-1:0] sync3_q;
    logic [SWW-1:0] closed_cnt_q;
    logic [SWW-1:0] sw_limit_cyc;
    logic [4:0] sw_limit_code;
    logic timeout_hit;
    logic charge_pulse;
    logic [EW-1:0] ev_cnt_q;
    logic [EW-1:0] run_cnt_q;
    logic [EW:0] run_next;
    logic timeout_irq_q;
    logic force_next_q;
    logic conv_active_q;
    logic conv_sleep_q;
    logic low_batt_q;
    logic [NR-1:0] charge_en_q;
    logic [IW-1:0] glob_cyc;
    logic [buck_ctrl_pkg::CTRL1_GLOBAL_IDLE_W-1:0] glob_code;
    logic mode_active;
    logic mode_sleep;

    // pins are asynchronous to clk: two flops, then a third stage for edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {rail_idle, charge_done, switch_closed, batt_below_2v5};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // shared control register writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl0_q <= buck_ctrl_pkg::CTRL0_RST;
            ctrl1_q <= buck_ctrl_pkg::CTRL1_RST;
            tt_q <= buck_ctrl_pkg::TIMEOUT_TRIM_RST;
        end else if (wr_en) begin
            if (addr == buck_ctrl_pkg::OFS_CTRL0) begin
                ctrl0_q <= wr_data & buck_ctrl_pkg::CTRL0_MASK; // bit 15 reserved
            end else if (addr == buck_ctrl_pkg::OFS_CTRL1) begin
                ctrl1_q <= wr_data;
            end else if (addr == buck_ctrl_pkg::OFS_TIMEOUT_TRIM) begin
                tt_q <= wr_data;
            end
        end
    end

    // trims go straight from the register flops to the analog side
    assign sense_current_trim = tt_q[buck_ctrl_pkg::TT_SENSE_LSB +: 2];
    assign low_side_supply_trim = tt_q[buck_ctrl_pkg::TT_LSSUP_LSB +: 3];
    assign high_side_ground_trim = tt_q[buck_ctrl_pkg::TT_HSGND_LSB +: 3];

    // mode decode; both unused encodings mean disabled
    always_comb begin
        mode_active = 1'b0;
        mode_sleep = 1'b0;
        case (buck_ctrl_pkg::conv_mode_t'(ctrl0_q[buck_ctrl_pkg::CTRL0_MODE_LSB +: 2]))
            buck_ctrl_pkg::MODE_ACTIVE: begin
                mode_active = 1'b1;
            end
            buck_ctrl_pkg::MODE_SLEEP: begin
                mode_sleep = 1'b1;
            end
            default: begin
                mode_active = 1'b0;
            end
        endcase
    end

    // mode and battery state flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_active_q <= 1'b0;
            conv_sleep_q <= 1'b0;
            low_batt_q <= 1'b0;
        end else begin
            conv_active_q <= mode_active;
            conv_sleep_q <= mode_sleep;
            low_batt_q <= ctrl0_q[buck_ctrl_pkg::CTRL0_BROWNOUT]
                & sync2_q[buck_ctrl_pkg::SYNC_BATT];
        end
    end

    // switch-closed timer; a zero limit code disables timeouts
    assign sw_limit_code = ctrl1_q[buck_ctrl_pkg::CTRL1_SW_LIMIT_LSB +: 5];
    assign sw_limit_cyc = SWW'(sw_limit_code * buck_ctrl_pkg::SW_STEP_CYC);
    assign timeout_hit = sync2_q[buck_ctrl_pkg::SYNC_SW] && (sw_limit_code != 5'h00)
        && (closed_cnt_q == sw_limit_cyc);
    assign charge_pulse = sync2_q[buck_ctrl_pkg::SYNC_CHG] & ~sync3_q[buck_ctrl_pkg::SYNC_CHG];
    assign run_next = {1'b0, run_cnt_q} + 5'h01;

    // counter saturates, so one long closure yields exactly one event
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            closed_cnt_q <= '0;
        end else if (!sync2_q[buck_ctrl_pkg::SYNC_SW]) begin
            closed_cnt_q <= '0;
        end else if (closed_cnt_q != '1) begin
            closed_cnt_q <= closed_cnt_q + 7'h01;
        end
    end

    // pulse that forces the switching sequencer to its next state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            force_next_q <= 1'b0;
        end else begin
            force_next_q <= timeout_hit;
        end
    end

    // timeout event counting; a timeout wins over a clean charge in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev_cnt_q <= '0;
            run_cnt_q <= '0;
        end else if (timeout_hit) begin
            if (ev_cnt_q != '1) begin
                ev_cnt_q <= ev_cnt_q + 4'h1;
            end
            run_cnt_q <= '0;
        end else if (charge_pulse) begin
            if (run_next >= {1'b0, tt_q[buck_ctrl_pkg::TT_CLR_RUN_LSB +: EW]}) begin
                ev_cnt_q <= '0;
                run_cnt_q <= '0;
            end else begin
                run_cnt_q <= run_next[EW-1:0];
            end
        end
    end

    // interrupt level follows the counter against the threshold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timeout_irq_q <= 1'b0;
        end else begin
            timeout_irq_q <= ev_cnt_q >= tt_q[buck_ctrl_pkg::TT_IRQ_THR_LSB +: EW];
        end
    end

    assign glob_code = ctrl1_q[buck_ctrl_pkg::CTRL1_GLOBAL_IDLE_LSB +:
        buck_ctrl_pkg::CTRL1_GLOBAL_IDLE_W];
    assign glob_cyc = IW'(glob_code * buck_ctrl_pkg::IDLE_STEP_CYC);

    // identical datapath per rail
    for (genvar i = 0; i < NR; i++) begin : g_rail
        logic [CW-1:0] min_code;
        logic [CW-1:0] max_code;
        logic [CW:0] idle_max_code;
        logic [IW-1:0] min_cyc;
        logic [IW-1:0] max_cyc;
        logic [IW-1:0] idle_cnt_q;
        logic idle_now;
        logic idle_prev;
        logic step_up;
        logic step_dn;
        logic step_fast_dn;
        logic [6:0] lim_w;

        // register writes for this rail
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rail0_q[i] <= buck_ctrl_pkg::RAIL0_RST[i];
                rail1_q[i] <= buck_ctrl_pkg::RAIL1_RST[i];
            end else if (wr_en) begin
                if (addr == buck_ctrl_pkg::OFS_RAIL0[i]) begin
                    rail0_q[i] <= wr_data;
                end else if (addr == buck_ctrl_pkg::OFS_RAIL1[i]) begin
                    rail1_q[i] <= wr_data;
                end
            end
        end

        // voltage code and ramp speed are used by the analog loop as stored
        assign rail_voltage_code[i*CW +: CW] = rail0_q[i][buck_ctrl_pkg::R0_VOLT_LSB +: CW];
        assign rail_fast_ramp[i] = rail0_q[i][buck_ctrl_pkg::R0_FAST];

        // charging enable picks the battery-mode bit, only when converter is active
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                charge_en_q[i] <= 1'b0;
            end else if (low_batt_q) begin
                charge_en_q[i] <= mode_active & rail1_q[i][buck_ctrl_pkg::R1_EN_LV];
            end else begin
                charge_en_q[i] <= mode_active & rail1_q[i][buck_ctrl_pkg::R1_EN_HV];
            end
        end

        // limits and idle windows in clock cycles
        assign min_code = rail0_q[i][buck_ctrl_pkg::R0_MIN_LSB +: CW];
        assign max_code = low_batt_q
            ? {1'b0, rail1_q[i][buck_ctrl_pkg::R1_MAX_LV_LSB +: buck_ctrl_pkg::LV_CODE_W]}
            : rail0_q[i][buck_ctrl_pkg::R0_MAX_HV_LSB +: CW];
        assign idle_max_code = {1'b0, rail1_q[i][buck_ctrl_pkg::R1_IDLE_MIN_LSB +: CW]}
            + {1'b0, rail1_q[i][buck_ctrl_pkg::R1_HYST_LSB +: CW]};
        assign min_cyc = IW'(rail1_q[i][buck_ctrl_pkg::R1_IDLE_MIN_LSB +: CW]
            * buck_ctrl_pkg::IDLE_STEP_CYC);
        assign max_cyc = IW'(idle_max_code * buck_ctrl_pkg::IDLE_STEP_CYC);
        assign idle_now = sync2_q[buck_ctrl_pkg::SYNC_IDLE0 + i];
        assign idle_prev = sync3_q[buck_ctrl_pkg::SYNC_IDLE0 + i];

        // idle time counter: restarts on each idle entry, saturates
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                idle_cnt_q <= '0;
            end else if (idle_now && !idle_prev) begin
                idle_cnt_q <= '0;
            end else if (idle_now && idle_cnt_q != '1) begin
                idle_cnt_q <= idle_cnt_q + 10'h001;
            end
        end

        // each threshold is crossed once per idle period, so each fires once
        assign step_up = !idle_now && idle_prev && (idle_cnt_q < min_cyc);
        assign step_dn = idle_now && idle_prev && (idle_cnt_q == max_cyc);
        assign step_fast_dn = idle_now && idle_prev && (glob_code != '0)
            && (idle_cnt_q == glob_cyc);

        // next limit, then clamp; max wins if software sets min above max
        always_comb begin
            lim_w = {2'b00, ilim_q[i]};
            if (step_up) begin
                lim_w = lim_w + (rail_fast_ramp[i] ? buck_ctrl_pkg::STEP_FAST
                    : buck_ctrl_pkg::STEP_NORMAL);
            end else if (step_fast_dn) begin
                lim_w = (lim_w > buck_ctrl_pkg::STEP_FAST_DOWN)
                    ? lim_w - buck_ctrl_pkg::STEP_FAST_DOWN : 7'h00;
            end else if (step_dn) begin
                lim_w = (lim_w > buck_ctrl_pkg::STEP_NORMAL)
                    ? lim_w - buck_ctrl_pkg::STEP_NORMAL : 7'h00;
            end
            if (lim_w < {2'b00, min_code}) begin
                lim_w = {2'b00, min_code};
            end
            if (lim_w > {2'b00, max_code}) begin
                lim_w = {2'b00, max_code};
            end
        end

        // adaptive limit flop, also clamped when limits are reprogrammed
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                ilim_q[i] <= buck_ctrl_pkg::ILIM_RST;
            end else begin
                ilim_q[i] <= lim_w[CW-1:0];
            end
        end

        assign adaptive_current_limit[i*CW +: CW] = ilim_q[i];
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        if (addr == buck_ctrl_pkg::OFS_CTRL0) begin
            rd_mux = ctrl0_q;
        end else if (addr == buck_ctrl_pkg::OFS_CTRL1) begin
            rd_mux = ctrl1_q;
        end else if (addr == buck_ctrl_pkg::OFS_TIMEOUT_TRIM) begin
            rd_mux = tt_q;
        end else if (addr == buck_ctrl_pkg::OFS_STATUS) begin
            // status from bit 0 up: event count, run count, irq, low battery, active, sleep
            rd_mux = {4'h0, conv_sleep_q, conv_active_q, low_batt_q, timeout_irq_q,
                4'h0, ev_cnt_q};
            rd_mux[EW +: EW] = run_cnt_q;
        end else if (addr == buck_ctrl_pkg::OFS_ILIM_LO) begin
            rd_mux = {6'h00, ilim_q[1], ilim_q[0]};
        end else if (addr == buck_ctrl_pkg::OFS_ILIM_HI) begin
            rd_mux = {6'h00, ilim_q[3], ilim_q[2]};
        end else begin
            for (int k = 0; k < NR; k++) begin
                if (addr == buck_ctrl_pkg::OFS_RAIL0[k]) begin
                    rd_mux = rail0_q[k];
                end
                if (addr == buck_ctrl_pkg::OFS_RAIL1[k]) begin
                    rd_mux = rail1_q[k];
                end
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= rd_mux;
        end else begin
            rd_data_q <= '0;
        end
    end

    assign rd_data = rd_data_q;
    assign converter_active = conv_active_q;
    assign converter_sleep = conv_sleep_q;
    assign low_batt_mode = low_batt_q;
    assign switch_force_next = force_next_q;
    assign timeout_irq = timeout_irq_q;
    assign rail_charge_en = charge_en_q;
endmodule

// ---- buck_multi_output_regulation_ctrl_chk.sv ----
// assertion checker watching the ports of the multi-output buck control block
`timescale 1ns/1ps
module buck_multi_output_regulation_ctrl_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic batt_below_2v5,
    input wire logic switch_closed,
    input wire logic converter_active,
    input wire logic converter_sleep,
    input wire logic low_batt_mode,
    input wire logic switch_force_next,
    input wire logic timeout_irq,
    input wire logic [1:0] sense_current_trim,
    input wire logic [2:0] low_side_supply_trim,
    input wire logic [2:0] high_side_ground_trim,
    input wire logic [19:0] rail_voltage_code,
    input wire logic [3:0] rail_fast_ramp,
    input wire logic [3:0] rail_charge_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // eight quiet cycles flush the pin synchroniser and the closed-time counter
    sequence s_switch_quiet;
        !switch_closed [*8];
    endsequence
    sequence s_batt_good;
        !batt_below_2v5 [*4];
    endsequence
    a_force_single_pulse: assert property (switch_force_next |=> !switch_force_next)
        else $error("switch force pulse longer than one cycle");
    a_force_needs_closed: assert property (s_switch_quiet |-> !switch_force_next)
        else $error("switch force without a closed switch");
    a_irq_after_event: assert property ($rose(timeout_irq) |->
        ($past(switch_force_next) || $past(switch_force_next, 2)))
        else $error("timeout interrupt rose without a timeout event");
    a_charge_needs_active: assert property (|rail_charge_en |-> converter_active)
        else $error("rail charging enabled outside active mode");
    a_mode_one_hot: assert property (!(converter_active && converter_sleep))
        else $error("active and sleep at once");
    a_low_batt_cause: assert property (s_batt_good |-> !low_batt_mode)
        else $error("low battery mode with a good battery");
    a_volt_code_held: assert property (!$past(wr_en) |-> $stable(rail_voltage_code))
        else $error("voltage code moved without a write");
    a_trim_held: assert property (!$past(wr_en) |-> $stable({sense_current_trim,
        low_side_supply_trim, high_side_ground_trim}))
        else $error("trim field moved without a write");
    a_fast_ramp_held: assert property (!$past(wr_en) |-> $stable(rail_fast_ramp))
        else $error("fast ramp bit moved without a write");
endmodule

bind buck_multi_output_regulation_ctrl buck_multi_output_regulation_ctrl_chk u_chk (
    .clk(clk), .nrst(nrst), .wr_en(wr_en), .batt_below_2v5(batt_below_2v5),
    .switch_closed(switch_closed), .converter_active(converter_active),
    .converter_sleep(converter_sleep), .low_batt_mode(low_batt_mode),
    .switch_force_next(switch_force_next), .timeout_irq(timeout_irq),
    .sense_current_trim(sense_current_trim), .low_side_supply_trim(low_side_supply_trim),
    .high_side_ground_trim(high_side_ground_trim), .rail_voltage_code(rail_voltage_code),
    .rail_fast_ramp(rail_fast_ramp), .rail_charge_en(rail_charge_en)
);

// ---- buck_multi_output_regulation_ctrl_bench.sv ----
// self-checking testbench of the multi-output buck control block
`timescale 1ns/1ps
module buck_multi_output_regulation_ctrl_bench;
    logic clk, nrst, wr_en, rd_en, batt, sw, chg, act, slp, lowb, force_nx, irq;
    logic [31:0] addr;
    logic [15:0] wr_data, rd_data;
    logic [3:0] idle, charge_en, fast;
    logic [1:0] sense;
    logic [2:0] lss, hsg;
    logic [19:0] volt, ilim;
    int miscompares, tests_run;
    int cycles = 0;

    buck_multi_output_regulation_ctrl dut (
        .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .batt_below_2v5(batt), .switch_closed(sw),
        .charge_done(chg), .rail_idle(idle), .converter_active(act), .converter_sleep(slp),
        .low_batt_mode(lowb), .switch_force_next(force_nx), .timeout_irq(irq),
        .sense_current_trim(sense), .low_side_supply_trim(lss), .high_side_ground_trim(hsg),
        .rail_voltage_code(volt), .rail_fast_ramp(fast), .rail_charge_en(charge_en),
        .adaptive_current_limit(ilim)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            finish_test;
        end
    end

    task automatic finish_test;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // two spare cycles let a field register settle before outputs are judged
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // read data stands one cycle only, then returns to zero
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        chk("rd_data", exp, rd_data);
        @(posedge clk);
        chk("rd_data_after", 16'h0000, rd_data);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic t_reset;
        rd(buck_ctrl_pkg::OFS_TIMEOUT_TRIM, {4'h8, 4'h8, 2'h0, 3'h5, 3'h5});
        for (int i = 0; i < 4; i++) begin
            rd(buck_ctrl_pkg::OFS_RAIL0[i], buck_ctrl_pkg::RAIL0_RST[i]);
            rd(buck_ctrl_pkg::OFS_RAIL1[i], buck_ctrl_pkg::RAIL1_RST[i]);
        end
        rd(buck_ctrl_pkg::OFS_RAIL0[2], {1'b1, 5'h10, 5'h18, 5'h04});
        rd(buck_ctrl_pkg::OFS_RAIL1[1], {2'b10, 4'hF, 5'h04, 5'h10});
        chk("volt", {5'h18, 5'h10, 5'h18, 5'h08}, volt);
        chk("ramp", 4'hF, fast);
        chk("ilim", {4{5'h04}}, ilim);
        chk("trim", {2'h0, 3'h5, 3'h5}, {sense, lss, hsg});
        wr(32'h5000_00A2, 16'hFFFF);
        rd(32'h5000_00A2, 16'h0000);
    endtask

    task automatic t_fields;
        for (int c = 0; c < 4; c++) begin
            wr(buck_ctrl_pkg::OFS_TIMEOUT_TRIM, {4'h2, 4'h2, c[1:0], 3'h7, 3'h2});
            chk("trim", {c[1:0], 3'h7, 3'h2}, {sense, lss, hsg});
        end
        for (int i = 0; i < 4; i++) begin
            wr(buck_ctrl_pkg::OFS_RAIL0[i], {1'b0, 5'h1F, 5'h1F, 5'h04});
            chk("volt", 5'h1F, volt[5*i +: 5]);
            chk("ramp", 1'b0, fast[i]);
        end
    endtask

    task automatic t_mode;
        wr(buck_ctrl_pkg::OFS_CTRL1, 16'h0081);
        wr(buck_ctrl_pkg::OFS_CTRL0, 16'h0002);
        chk("sleep", 3'b010, {act, slp, |charge_en});
        wr(buck_ctrl_pkg::OFS_CTRL0, 16'h0003);
        chk("off", 3'b000, {act, slp, |charge_en});
        wr(buck_ctrl_pkg::OFS_CTRL0, 16'h0001);
        chk("charge_en", {1'b1, 4'hF}, {act, charge_en});
        wr(buck_ctrl_pkg::OFS_CTRL0, 16'h2001);
        batt <= 1'b1;
        wait_clk(6);
        chk("low_batt", {1'b1, 4'b0101}, {lowb, charge_en});
        batt <= 1'b0;
        wait_clk(6);
        chk("charge_en", {1'b0, 4'hF}, {lowb, charge_en});
    endtask

    task automatic close_sw(input int exp_pulses);
        int n;
        n = 0;
        sw <= 1'b1;
        repeat (20) begin
            @(posedge clk);
            if (force_nx === 1'b1) n++;
        end
        sw <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            if (force_nx === 1'b1) n++;
        end
        chk("force_pulses", exp_pulses, n);
    endtask

    task automatic pulse_chg;
        chg <= 1'b1;
        @(posedge clk);
        chg <= 1'b0;
        wait_clk(6);
    endtask

    task automatic t_timeout;
        close_sw(1);
        chk("irq", 1'b0, irq);
        close_sw(1);
        chk("irq", 1'b1, irq);
        rd(buck_ctrl_pkg::OFS_STATUS, {4'h0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 4'h2});
        pulse_chg;
        chk("irq", 1'b1, irq);
        pulse_chg;
        chk("irq", 1'b0, irq);
        wr(buck_ctrl_pkg::OFS_CTRL1, 16'h0080);
        close_sw(0);
    endtask

    task automatic idle_pulse(input int n, input logic [4:0] exp);
        idle[0] <= 1'b1;
        wait_clk(n);
        idle[0] <= 1'b0;
        wait_clk(8);
        chk("ilim0", exp, ilim[4:0]);
    endtask

    // rail 0: idle minimum 10 cycles, idle maximum 15, global ceiling 20
    task automatic t_adapt;
        wr(buck_ctrl_pkg::OFS_RAIL0[0], {1'b0, 5'h08, 5'h06, 5'h02});
        wr(buck_ctrl_pkg::OFS_RAIL1[0], {2'b11, 4'h3, 5'h01, 5'h02});
        idle_pulse(3, 5'h05);
        idle_pulse(3, 5'h06);
        idle_pulse(3, 5'h06);
        idle_pulse(17, 5'h05);
        idle_pulse(17, 5'h04);
        wr(buck_ctrl_pkg::OFS_RAIL0[0], {1'b1, 5'h08, 5'h06, 5'h02});
        idle_pulse(3, 5'h06);
        idle_pulse(26, 5'h02);
        idle_pulse(3, 5'h04);
        chk("ilim2", 5'h04, ilim[14:10]);
        batt <= 1'b1;
        wait_clk(6);
        chk("ilim0_low_batt", 5'h03, ilim[4:0]);
        rd(buck_ctrl_pkg::OFS_ILIM_LO, {6'h00, 5'h04, 5'h03});
    endtask

    initial begin
        nrst = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wr_data = '0;
        batt = 1'b0;
        sw = 1'b0;
        chg = 1'b0;
        idle = 4'h0;
        miscompares = 0;
        tests_run = 0;
        wait_clk(2);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset;
        t_fields;
        t_mode;
        t_timeout;
        t_adapt;
        finish_test;
    end
endmodule
